// *** urx_pkg.sv ***
`default_nettype none
package urx_pkg;
  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] URX_CTRL_OFS = 8'h00;
  localparam logic [7:0] URX_STAT_OFS = 8'h04;
  localparam logic [7:0] URX_DATA_OFS = 8'h08;
  localparam logic [7:0] URX_ISTAT_OFS = 8'h0C;
  localparam logic [7:0] URX_IMASK_OFS = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int URX_CTRL_SERIAL_PORT_ENABLE_BIT = 0;
  localparam int URX_CTRL_CONTINUOUS_RECEIVE_ENABLE_BIT = 1;
  localparam int URX_CTRL_RX9 = 2;
  localparam int URX_CTRL_ADDRESS_DETECT_ENABLE_BIT = 3;
  localparam int URX_STAT_FRAMING_ERROR_FLAG = 0;
  localparam int URX_STAT_OVERRUN_ERROR_FLAG = 1;
  localparam int URX_STAT_RECEIVED_NINTH_BIT = 2;
  localparam int URX_STAT_RECEIVE_INTERRUPT_FLAG = 3;
  localparam int URX_STAT_CNT = 4;
  localparam int URX_IRQ_RX = 0;
  localparam int URX_IRQ_OVR = 1;
  localparam int URX_IRQ_W = 2;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [3:0] URX_CTRL_RST = 4'h0;
  localparam logic [1:0] URX_IMASK_RST = 2'h0;
  localparam int URX_FIFO_DEPTH = 2;

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  localparam int URX_CLK_HZ = 125000000;
  localparam int URX_BAUD = 115200;
  localparam int URX_CLKS_PER_BIT = URX_CLK_HZ / URX_BAUD;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic framing_error_flag;
    logic [8:0] data;
  } urx_char_t;

  typedef struct packed {
    logic address_detect_enable_bit;
    logic nine_bit_receive_select;
    logic continuous_receive_enable_bit;
    logic serial_port_enable_bit;
  } urx_ctrl_t;
endpackage
`default_nettype wire

// *** urx_recv_status.sv ***
// Summary of operation
// RULE_01 - Each stored character keeps its own framing error bit from its stop bit.
// RULE_02 - Visible framing flag is read-only and shows only the oldest unread character.
// RULE_03 - Software reads the framing flag before reading received data.
// RULE_04 - Framing errors never stop reception and need no clearing.
// RULE_05 - Reading received data advances the FIFO and the visible flag.
// RULE_06 - Clearing the port enable resets the port and zeroes the framing flag.
// RULE_07 - Clearing continuous receive enable leaves the framing flag as it is.
// RULE_08 - A framing error alone raises no interrupt.
// RULE_09 - The receive FIFO holds up to two whole characters.
// RULE_10 - A third complete character with two unread sets the overrun flag.
// RULE_11 - During overrun, stored characters stay readable; new ones are refused.
// RULE_12 - Overrun clears only when receive enable or port enable is cleared.
// RULE_13 - In nine-bit mode each character shifts in nine data bits.
// RULE_14 - Ninth bit of the top character is shown; read it before data.
// RULE_15 - Address detect enable turns on address mode, only with nine-bit reception.
// RULE_16 - In address mode only characters with ninth bit one are stored.
// RULE_17 - Software drops address mode after a match and restores it after message.
// RULE_18 - Receive flag stays high while the FIFO holds an unread character.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module urx_recv_status
  import urx_pkg::*;
#(
  parameter int DEPTH = URX_FIFO_DEPTH,
  parameter int CLKS_PER_BIT = URX_CLKS_PER_BIT
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Serial line
  input wire logic rx_i,
  // Interrupt
  output logic irq_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNW = $clog2(DEPTH + 1);
  localparam logic [CNW-1:0] CNT_FULL = CNW'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  if (DEPTH < 1 || DEPTH > 8) begin : g_bad_depth
    $error("DEPTH must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [PW-1:0] inc_ptr(input logic [PW-1:0] p);
    inc_ptr = (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  urx_ctrl_t ctrl;
  logic [URX_IRQ_W-1:0] imask;
  logic [URX_IRQ_W-1:0] istat;
  logic [URX_IRQ_W-1:0] next_istat;
  logic [URX_IRQ_W-1:0] irq_evt;
  logic overrun_error_flag;
  urx_char_t mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CNW-1:0] count;
  logic chr_valid;
  urx_char_t chr;
  logic rx_en;
  logic addr_mode;
  logic addr_ok;
  logic push_try;
  logic full;
  logic pop;
  logic push;
  logic ovr_evt;
  logic receive_interrupt_flag;
  logic framing_error_flag_vis;
  logic received_ninth_bit_vis;
  urx_char_t top;

  assign rx_en = ctrl.serial_port_enable_bit && ctrl.continuous_receive_enable_bit;
  assign top = mem[rd_ptr];
  assign full = (count == CNT_FULL);
  assign receive_interrupt_flag = (count != '0);

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  urx_rx_shift #(
    .CLKS_PER_BIT(CLKS_PER_BIT)
  ) u_shift (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(rx_en),
    .nine_i(ctrl.nine_bit_receive_select),
    .rx_i(rx_i),
    .char_valid_o(chr_valid),
    .char_o(chr)
  );

  // ----------------------------------------------------------------
  // Acceptance into the FIFO
  // ----------------------------------------------------------------
  // RULE_15 address mode needs nine bits
  assign addr_mode = ctrl.address_detect_enable_bit && ctrl.nine_bit_receive_select;
  // RULE_16 discard non-address characters
  assign addr_ok = !addr_mode || chr.data[8];
  // RULE_04 framing error never blocks
  // RULE_11 refuse while overrun
  assign push_try = chr_valid && addr_ok && !overrun_error_flag;
  // RULE_05 data read pops
  assign pop = rd_i && hit(addr_i, URX_DATA_OFS) && receive_interrupt_flag;
  // RULE_09 two entries
  assign push = push_try && (!full || pop);
  // RULE_10 third character overruns
  assign ovr_evt = push_try && full && !pop;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl <= URX_CTRL_RST;
    end else if (wr_i && hit(addr_i, URX_CTRL_OFS)) begin
      ctrl <= wdata_i[3:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      imask <= URX_IMASK_RST;
    end else if (wr_i && hit(addr_i, URX_IMASK_OFS)) begin
      imask <= wdata_i[URX_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Overrun flag
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      overrun_error_flag <= 1'b0;
    // RULE_12 cleared by enables only
    end else if (!rx_en) begin
      overrun_error_flag <= 1'b0;
    end else if (ovr_evt) begin
      overrun_error_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Character FIFO
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    // RULE_07 receive enable clear keeps FIFO
    // RULE_06 port enable clear flushes
    end else if (!ctrl.serial_port_enable_bit) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= inc_ptr(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= inc_ptr(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // RULE_01 framing bit stored per entry
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (push) begin
      mem[wr_ptr] <= chr;
    end
  end

  // RULE_02 flag follows top entry
  assign framing_error_flag_vis = receive_interrupt_flag && top.framing_error_flag;
  // RULE_14 ninth bit of top entry
  assign received_ninth_bit_vis = receive_interrupt_flag && top.data[8];

  // ----------------------------------------------------------------
  // Interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------
  // RULE_08 framing error not an event
  assign irq_evt = {ovr_evt, push};

  always_comb begin
    next_istat = istat;
    if (wr_i && hit(addr_i, URX_ISTAT_OFS)) begin
      next_istat = istat & ~wdata_i[URX_IRQ_W-1:0];
    end
    next_istat = next_istat | irq_evt;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      istat <= '0;
      irq_o <= 1'b0;
    end else begin
      istat <= next_istat;
      irq_o <= |(next_istat & imask);
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= 32'h0000_0000;
      if (hit(addr_i, URX_CTRL_OFS)) begin
        rdata_o[3:0] <= ctrl;
      end else if (hit(addr_i, URX_STAT_OFS)) begin
        rdata_o[URX_STAT_FRAMING_ERROR_FLAG] <= framing_error_flag_vis;
        rdata_o[URX_STAT_OVERRUN_ERROR_FLAG] <= overrun_error_flag;
        rdata_o[URX_STAT_RECEIVED_NINTH_BIT] <= received_ninth_bit_vis;
        // RULE_18 receive flag from fill level
        rdata_o[URX_STAT_RECEIVE_INTERRUPT_FLAG] <= receive_interrupt_flag;
        rdata_o[URX_STAT_CNT +: CNW] <= count;
      end else if (hit(addr_i, URX_DATA_OFS)) begin
        rdata_o[7:0] <= receive_interrupt_flag ? top.data[7:0] : 8'h00;
      end else if (hit(addr_i, URX_ISTAT_OFS)) begin
        rdata_o[URX_IRQ_W-1:0] <= istat;
      end else if (hit(addr_i, URX_IMASK_OFS)) begin
        rdata_o[URX_IRQ_W-1:0] <= imask;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // RULE_02 top entry flag
  AST_FRAMING_ERROR_FLAG_NEXT: assert property (pop && count == 2 && !push && ctrl.serial_port_enable_bit
      |=> framing_error_flag_vis == $past(mem[inc_ptr(rd_ptr)].framing_error_flag)) // RULE_05
    else $error("framing flag did not move to next character");

  // RULE_06 port disable clears
  AST_SERIAL_PORT_ENABLE_BIT_CLR: assert property (!ctrl.serial_port_enable_bit |=> !framing_error_flag_vis && !overrun_error_flag) // RULE_06
    else $error("port disable left flags set");

  // RULE_07 receive disable keeps flag
  AST_CONTINUOUS_RECEIVE_ENABLE_BIT_KEEP: assert property (ctrl.serial_port_enable_bit
      && !ctrl.continuous_receive_enable_bit && !pop && !chr_valid
      |=> framing_error_flag_vis == $past(framing_error_flag_vis)) // RULE_07
    else $error("receive disable changed framing flag");

  // RULE_08 no framing interrupt
  AST_NO_FRAMING_ERROR_FLAG_IRQ: assert property ($rose(istat[URX_IRQ_RX]) |-> $past(push)) // RULE_08
    else $error("receive event without stored character");

  // RULE_09 fill bound
  AST_FILL_MAX: assert property (count <= CNT_FULL) // RULE_09
    else $error("FIFO holds more than its depth");

  // RULE_10 overrun raised
  AST_OVR_SET: assert property (ovr_evt && rx_en |=> overrun_error_flag && count == $past(count)) // RULE_10
    else $error("overrun not flagged or character kept");

  // RULE_11 nothing accepted in overrun
  AST_OVR_BLOCK: assert property (overrun_error_flag |-> !push) // RULE_11
    else $error("character stored during overrun");

  // RULE_12 overrun sticks while enabled
  AST_OVR_HOLD: assert property (overrun_error_flag && rx_en |=> overrun_error_flag) // RULE_12
    else $error("overrun cleared without enable change");

  // RULE_16 address filter
  AST_ADDR_FILTER: assert property (chr_valid && addr_mode && !chr.data[8] |-> !push) // RULE_16
    else $error("data character stored in address mode");

  // RULE_18 flag drops when emptied
  AST_RECEIVE_INTERRUPT_FLAG_DROP: assert property (pop && count == 1 && !push |=> !receive_interrupt_flag) // RULE_18
    else $error("receive flag stuck after last read");

  // RULE_02 status read back
  AST_STAT_READ: assert property (rd_i && hit(addr_i, URX_STAT_OFS) // RULE_02
      |=> rdata_o[URX_STAT_RECEIVE_INTERRUPT_FLAG] == $past(receive_interrupt_flag) && rdata_o[URX_STAT_FRAMING_ERROR_FLAG] == $past(framing_error_flag_vis))
    else $error("status read does not match state");

  // RULE_04 framing error still stored
  AST_FRAMING_ERROR_FLAG_ACCEPT: assert property (chr_valid && chr.framing_error_flag && push_try && !full // RULE_04
      |-> push)
    else $error("character with framing error refused");

  // RULE_05 data read shows top
  AST_DATA_READ: assert property (rd_i && hit(addr_i, URX_DATA_OFS) && receive_interrupt_flag // RULE_05
      |=> rdata_o[7:0] == $past(top.data[7:0]))
    else $error("data read did not return top character");

  // RULE_08 interrupt only from status
  AST_IRQ_LEVEL: assert property (1'b1 |=> irq_o == |(istat & $past(imask))) // RULE_08
    else $error("interrupt output differs from masked status");

  // RULE_10 overrun event latched
  AST_OVR_EVENT: assert property (ovr_evt |=> istat[URX_IRQ_OVR]) // RULE_10
    else $error("overrun event not latched");

  // RULE_12 enable clear drops overrun
  AST_OVR_CLEAR: assert property (!rx_en |=> !overrun_error_flag) // RULE_12
    else $error("overrun kept while receive disabled");

  // RULE_15 address mode needs nine bits
  AST_NINE_ONLY: assert property (chr_valid && !ctrl.nine_bit_receive_select |-> addr_ok) // RULE_15
    else $error("address filter active in 8-bit mode");

  // RULE_16 stored character raises event
  AST_PUSH_EVENT: assert property (push |=> istat[URX_IRQ_RX]) // RULE_16
    else $error("stored character did not set receive event");

  // RULE_18 flag held while not empty
  AST_RECEIVE_INTERRUPT_FLAG_HOLD: assert property (receive_interrupt_flag && !pop && ctrl.serial_port_enable_bit |=> receive_interrupt_flag) // RULE_18
    else $error("receive flag dropped with characters stored");

  COV_OVERRUN: cover property (full ##[1:1000] ovr_evt);
  COV_ADDR_CHAR: cover property (chr_valid && addr_mode && chr.data[8]);
  COV_FRAMING_ERROR_FLAG_POP: cover property (framing_error_flag_vis && pop);
  COV_NINE_BIT: cover property (received_ninth_bit_vis ##1 pop);
  COV_ADDR_DROP: cover property (chr_valid && addr_mode && !chr.data[8]);
endmodule // urx_recv_status
`default_nettype wire

// *** urx_recv_status_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module urx_recv_status_tb
  import urx_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic rx;
  logic irq;
  logic go = 1'b0;
  logic [8:0] chr = 9'h000;
  logic nine = 1'b0;
  logic bad_stop = 1'b0;
  logic busy;
  int fails = 0;
  int compares = 0;

  urx_recv_status #(.CLKS_PER_BIT(8)) dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_i(rx), .irq_o(irq));

  urx_tx_model #(.CLKS_PER_BIT(8)) far_end (
    .core_clk_i(core_clk), .go_i(go), .char_i(chr), .nine_i(nine),
    .bad_i(bad_stop), .rx_o(rx), .busy_o(busy));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  task automatic send(input logic [8:0] c, input logic n9, input logic bad);
    int n;
    @(posedge core_clk);
    go <= 1'b1;
    chr <= c;
    nine <= n9;
    bad_stop <= bad;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
    for (n = 0; n < 200 && busy === 1'b1; n++) @(posedge core_clk);
    if (n == 200) begin
      fails++;
      summarize();
    end
  endtask

  // Status word: count, fifo not empty, ninth bit, overrun, framing
  function automatic logic [31:0] st(input logic [1:0] c, input logic f, input logic o,
                                     input logic n9);
    return {26'h0, c, (c != 2'h0), n9, o, f};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(URX_CTRL_OFS, 32'h0);
    rd_chk(URX_STAT_OFS, 32'h0);
    wr_reg(8'h14, 32'hFFFFFFFF);
    rd_chk(8'h14, 32'h0);
    wr_reg(URX_CTRL_OFS, 32'h3);
    wr_reg(URX_IMASK_OFS, 32'h3);
    send(9'h0A5, 1'b0, 1'b0);
    send(9'h03C, 1'b0, 1'b1);
    rd_chk(URX_STAT_OFS, st(2'h2, 1'b0, 1'b0, 1'b0));
    rd_chk(URX_ISTAT_OFS, 32'h1);
    `CHK(irq, 1'b1)
    rd_chk(URX_DATA_OFS, 32'hA5);
    rd_chk(URX_STAT_OFS, st(2'h1, 1'b1, 1'b0, 1'b0));
    wr_reg(URX_STAT_OFS, 32'h0);
    rd_chk(URX_STAT_OFS, st(2'h1, 1'b1, 1'b0, 1'b0));
    rd_chk(URX_DATA_OFS, 32'h3C);
    rd_chk(URX_STAT_OFS, st(2'h0, 1'b0, 1'b0, 1'b0));
    rd_chk(URX_DATA_OFS, 32'h0);
    wr_reg(URX_ISTAT_OFS, 32'h1);
    rd_chk(URX_ISTAT_OFS, 32'h0);
    `CHK(irq, 1'b0)
    // Overrun: third whole character with two unread
    send(9'h011, 1'b0, 1'b1);
    send(9'h022, 1'b0, 1'b0);
    send(9'h033, 1'b0, 1'b0);
    rd_chk(URX_STAT_OFS, st(2'h2, 1'b1, 1'b1, 1'b0));
    rd_chk(URX_ISTAT_OFS, 32'h3);
    send(9'h044, 1'b0, 1'b0);
    rd_chk(URX_STAT_OFS, st(2'h2, 1'b1, 1'b1, 1'b0));
    wr_reg(URX_IMASK_OFS, 32'h0);
    @(posedge core_clk);
    #1 `CHK(irq, 1'b0)
    wr_reg(URX_ISTAT_OFS, 32'h3);
    wr_reg(URX_CTRL_OFS, 32'h1);
    rd_chk(URX_STAT_OFS, st(2'h2, 1'b1, 1'b0, 1'b0));
    rd_chk(URX_DATA_OFS, 32'h11);
    rd_chk(URX_DATA_OFS, 32'h22);
    wr_reg(URX_CTRL_OFS, 32'h3);
    send(9'h055, 1'b0, 1'b0);
    rd_chk(URX_STAT_OFS, st(2'h1, 1'b0, 1'b0, 1'b0));
    rd_chk(URX_DATA_OFS, 32'h55);
    // Port disable flushes and clears the framing flag
    send(9'h0F0, 1'b0, 1'b1);
    rd_chk(URX_STAT_OFS, st(2'h1, 1'b1, 1'b0, 1'b0));
    wr_reg(URX_CTRL_OFS, 32'h0);
    rd_chk(URX_STAT_OFS, 32'h0);
    // Nine-bit characters
    wr_reg(URX_CTRL_OFS, 32'h7);
    send(9'h1AB, 1'b1, 1'b0);
    send(9'h0CD, 1'b1, 1'b0);
    rd_chk(URX_STAT_OFS, st(2'h2, 1'b0, 1'b0, 1'b1));
    rd_chk(URX_DATA_OFS, 32'hAB);
    rd_chk(URX_STAT_OFS, st(2'h1, 1'b0, 1'b0, 1'b0));
    rd_chk(URX_DATA_OFS, 32'hCD);
    // Address detection
    wr_reg(URX_CTRL_OFS, 32'hF);
    send(9'h055, 1'b1, 1'b0);
    rd_chk(URX_STAT_OFS, 32'h0);
    send(9'h166, 1'b1, 1'b0);
    rd_chk(URX_STAT_OFS, st(2'h1, 1'b0, 1'b0, 1'b1));
    // Address matched: software leaves address mode for the message
    wr_reg(URX_CTRL_OFS, 32'h7);
    send(9'h077, 1'b1, 1'b0);
    rd_chk(URX_STAT_OFS, st(2'h2, 1'b0, 1'b0, 1'b1));
    rd_chk(URX_DATA_OFS, 32'h66);
    rd_chk(URX_DATA_OFS, 32'h77);
    wr_reg(URX_CTRL_OFS, 32'hF);
    rd_chk(URX_CTRL_OFS, 32'hF);
    summarize();
  end
endmodule // urx_recv_status_tb
`default_nettype wire

// *** urx_rx_shift.sv ***
`timescale 1ns/1ns
`default_nettype none
module urx_rx_shift
  import urx_pkg::*;
#(
  parameter int CLKS_PER_BIT = URX_CLKS_PER_BIT
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic en_i,
  input wire logic nine_i,
  // Serial line
  input wire logic rx_i,
  // Received character
  output logic char_valid_o,
  output urx_char_t char_o
);
  localparam int CW = $clog2(CLKS_PER_BIT + 1);
  localparam logic [CW-1:0] FULL = CW'(CLKS_PER_BIT - 1);
  localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2);

  if (CLKS_PER_BIT < 4) begin : g_bad_rate
    $error("CLKS_PER_BIT must be at least 4");
  end

  typedef enum logic [1:0] {RS_IDLE, RS_START, RS_DATA, RS_STOP} urx_rs_t;

  urx_rs_t st;
  logic [CW-1:0] cnt;
  logic [3:0] idx;
  logic [8:0] shreg;
  logic tick;

  assign tick = (cnt == '0) && (st != RS_IDLE);

  // ----------------------------------------------------------------
  // Bit-rate divider, one-cycle tick at each sample point
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !en_i || st == RS_IDLE) begin
      cnt <= HALF;
    end else if (tick) begin
      cnt <= FULL;
    end else begin
      cnt <= cnt - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !en_i) begin
      st <= RS_IDLE;
      idx <= 4'h0;
      shreg <= 9'h000;
      char_valid_o <= 1'b0;
      char_o <= '0;
    end else begin
      char_valid_o <= 1'b0;
      unique case (st)
        RS_IDLE: begin
          if (!rx_i) begin
            st <= RS_START;
          end
        end
        RS_START: begin
          if (tick) begin
            idx <= 4'h0;
            st <= rx_i ? RS_IDLE : RS_DATA;
          end
        end
        // RULE_13 nine data bits
        RS_DATA: begin
          if (tick) begin
            shreg <= {rx_i, shreg[8:1]};
            idx <= idx + 1'b1;
            if (idx == (nine_i ? 4'h8 : 4'h7)) begin
              st <= RS_STOP;
            end
          end
        end
        // RULE_01 stop bit check
        RS_STOP: begin
          if (tick) begin
            char_o.framing_error_flag <= !rx_i;
            char_o.data <= nine_i ? shreg : {1'b0, shreg[8:1]};
            char_valid_o <= 1'b1;
            st <= RS_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // RULE_13 ninth bit zero in 8-bit mode
  AST_NINE_BIT: assert property (char_valid_o && !nine_i |-> !char_o.data[8]) // RULE_13
    else $error("ninth bit set in 8-bit mode");
endmodule // urx_rx_shift
`default_nettype wire

// *** urx_tx_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module urx_tx_model
  import urx_pkg::*;
#(
  parameter int CLKS_PER_BIT = 8
) (
  // Clock
  input wire logic core_clk_i,
  // Request from bench
  input wire logic go_i,
  input wire logic [8:0] char_i,
  input wire logic nine_i,
  input wire logic bad_i,
  // Serial line and status
  output var logic rx_o,
  output var logic busy_o
);
  // ----------------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------------
  initial begin
    logic [10:0] frame;
    int nb;
    rx_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge core_clk_i);
      if (go_i) begin
        nb = nine_i ? 11 : 10;
        // Start low, data LSB first, stop high unless told to break it
        frame = nine_i ? {~bad_i, char_i, 1'b0} : {1'b1, ~bad_i, char_i[7:0], 1'b0};
        busy_o <= 1'b1;
        // Extra idle bit keeps a broken stop from looking like a start
        for (int b = 0; b <= nb; b++) begin
          rx_o <= (b < nb) ? frame[b] : 1'b1;
          repeat (CLKS_PER_BIT) @(posedge core_clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule // urx_tx_model
`default_nettype wire
